// ===== core/twr_map.vh
// Constants for the two-wire register host controller
// Functional notes
// - Serial clock at most pixel clock over 22
// - Register addresses always sixteen bits wide
// - Data moved as sixteen-bit words only
// - Start: data falls, stop: data rises, clock high
// - Bytes MSB first, each followed by acknowledge
// - Data changes only while clock is low
// - Transmitter releases data; receiver pulls low
// - Data left high means no-acknowledge
// - Host ends write with stop or restart
// - Read: address write, restart, read byte
// - Random read: dummy write, restart, read, stop
// - Host ends a plain write with a stop; a read's address write ends with a restart
// - Register address high byte first, then low
`ifndef TWR_MAP_VH
`define TWR_MAP_VH
`define TWR_MCLK_MHZ 200
`define TWR_PIX_DIV 22
`define TWR_SLA_LO 7'h48
`define TWR_SLA_HI 7'h5D
`define TWR_DIR_WR 1'b0
`define TWR_DIR_RD 1'b1
`define TWR_STG_SLAW 3'h0
`define TWR_STG_AHI 3'h1
`define TWR_STG_ALO 3'h2
`define TWR_STG_DATA 3'h3
`define TWR_STG_SLAR 3'h4
`define TWR_PH_0 2'h0
`define TWR_PH_1 2'h1
`define TWR_PH_2 2'h2
`define TWR_PH_3 2'h3
`define TWR_FREE_QTRS 4'h4
`endif

// ===== core/twr_sync.v
// Two-flop synchroniser for one pin input
`timescale 1ns/10ps
module twr_sync #(
  parameter RST_VAL = 1'b1
) (
  input wire clk,
  input wire rst_b,
  input wire d,
  output wire q
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule

// ===== core/twr_buf2.v
// Two-entry valid/ready buffer for read data
`timescale 1ns/10ps
module twr_buf2 #(
  parameter W = 8
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg wr_q;
  reg rd_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

// ===== core/twr_host.v
// Two-wire bus master that reads and writes sensor registers
`timescale 1ns/10ps
`include "twr_map.vh"
module twr_host #(
  parameter PIX_MHZ = 96,
  parameter LEN_W = 8
) (
  input wire MCLK,
  input wire RST_B,
  input wire CMD_VALID,
  output wire CMD_READY,
  input wire CMD_READ,
  input wire CMD_CUR,
  input wire CMD_SEL,
  input wire [15:0] CMD_ADDR,
  input wire [LEN_W-1:0] CMD_WORDS,
  input wire WR_VALID,
  output wire WR_READY,
  input wire [7:0] WR_DATA,
  output wire RD_VALID,
  input wire RD_READY,
  output wire [7:0] RD_DATA,
  output wire BUSY,
  output wire DONE,
  output wire NACK,
  input wire SCL_I,
  output wire SCL_O,
  output wire SCL_OE,
  input wire SDA_I,
  output wire SDA_O,
  output wire SDA_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit timing from the pixel clock limit

  // Round up so the bus never runs faster than allowed
  localparam integer QTR_RAW = (`TWR_MCLK_MHZ * `TWR_PIX_DIV + 4 * PIX_MHZ - 1) /
    (4 * PIX_MHZ);
  localparam integer QTR = (QTR_RAW < 1) ? 1 : QTR_RAW;
  localparam [31:0] QTR_M1 = QTR - 1;
  localparam [7:0] QTR_LAST = QTR_M1[7:0];

  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_START = 9'h002;
  localparam [8:0] S_TX = 9'h004;
  localparam [8:0] S_RXACK = 9'h008;
  localparam [8:0] S_RX = 9'h010;
  localparam [8:0] S_PUSH = 9'h020;
  localparam [8:0] S_TXACK = 9'h040;
  localparam [8:0] S_STOP = 9'h080;
  localparam [8:0] S_FETCH = 9'h100;

  function [7:0] sla_byte;
    input sel;
    input rd;
    begin
      sla_byte = {(sel ? `TWR_SLA_HI : `TWR_SLA_LO), rd};
    end
  endfunction

  reg [7:0] qcnt_q;
  reg [8:0] state_q;
  reg fetch_q;
  reg [1:0] ph_q;
  reg [2:0] bit_q;
  reg [7:0] sh_q;
  reg [2:0] stage_q;
  reg sel_q;
  reg rd_q;
  reg [15:0] addr_q;
  reg [LEN_W:0] cnt_q;
  reg scl_oe_q;
  reg sda_oe_q;
  reg done_q;
  reg nack_q;
  reg ack_q;
  reg bus_busy_q;
  reg [3:0] free_q;
  reg sda_p_q;
  reg scl_p_q;
  wire tick;
  wire scl_s;
  wire sda_s;
  wire stretch;
  wire adv;
  wire buf_ready;
  wire push;
  wire start_seen;
  wire stop_seen;
  wire bus_free;

  ////////////////////////////////////////////////////////////////////////////
  // Divider and pin sampling

  assign tick = (qcnt_q == QTR_LAST);

  always @(posedge MCLK) begin
    if (!RST_B) begin
      qcnt_q <= 8'h00;
    end else if (tick) begin
      qcnt_q <= 8'h00;
    end else begin
      qcnt_q <= qcnt_q + 8'h01;
    end
  end

  twr_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .d(SCL_I),
    .q(scl_s)
  );

  twr_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .d(SDA_I),
    .q(sda_s)
  );

  // A released clock still held low by the far side stalls the bit
  assign stretch = ~scl_oe_q & ~scl_s & ph_q[1];
  assign adv = tick & ~stretch;

  ////////////////////////////////////////////////////////////////////////////
  // Bus monitor

  always @(posedge MCLK) begin
    if (!RST_B) begin
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
    end else begin
      sda_p_q <= sda_s;
      scl_p_q <= scl_s;
    end
  end

  assign start_seen = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_seen = scl_s & scl_p_q & ~sda_p_q & sda_s;

  always @(posedge MCLK) begin
    if (!RST_B) begin
      bus_busy_q <= 1'b0;
      free_q <= 4'h0;
    end else begin
      if (start_seen) begin
        bus_busy_q <= 1'b1;
      end else if (stop_seen) begin
        bus_busy_q <= 1'b0;
      end
      if (~scl_s | ~sda_s | bus_busy_q) begin
        free_q <= 4'h0;
      end else if (tick & (free_q != `TWR_FREE_QTRS)) begin
        free_q <= free_q + 4'h1;
      end
    end
  end

  // Both lines high for a few quarters before a new start
  assign bus_free = ~bus_busy_q & scl_s & sda_s & (free_q == `TWR_FREE_QTRS);

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes

  assign CMD_READY = (state_q == S_IDLE) & bus_free;
  assign WR_READY = fetch_q & (state_q == S_FETCH);
  assign push = (state_q == S_PUSH) & buf_ready;

  twr_buf2 #(.W(8)) u_rd_buf (
    .clk(MCLK),
    .rst_b(RST_B),
    .in_valid(state_q == S_PUSH),
    .in_ready(buf_ready),
    .in_data(sh_q),
    .out_valid(RD_VALID),
    .out_ready(RD_READY),
    .out_data(RD_DATA)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer

  always @(posedge MCLK) begin
    if (!RST_B) begin
      state_q <= S_IDLE;
      fetch_q <= 1'b0;
      ph_q <= `TWR_PH_0;
      bit_q <= 3'h7;
      sh_q <= 8'h00;
      stage_q <= `TWR_STG_SLAW;
      sel_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 16'h0000;
      cnt_q <= {(LEN_W + 1){1'b0}};
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          fetch_q <= 1'b0;
          if (CMD_VALID & CMD_READY) begin
            sel_q <= CMD_SEL;
            rd_q <= CMD_READ;
            addr_q <= CMD_ADDR;
            // Whole words only; an empty read still fetches one word
            if (CMD_READ & (CMD_WORDS == {LEN_W{1'b0}})) begin
              cnt_q <= {{(LEN_W - 1){1'b0}}, 2'h2};
            end else begin
              cnt_q <= {CMD_WORDS, 1'b0};
            end
            stage_q <= (CMD_READ & CMD_CUR) ? `TWR_STG_SLAR : `TWR_STG_SLAW;
            nack_q <= 1'b0;
            ph_q <= `TWR_PH_0;
            state_q <= S_START;
          end
        end
        S_START: begin
          if (adv) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              `TWR_PH_0: sda_oe_q <= 1'b0;
              `TWR_PH_1: scl_oe_q <= 1'b0;
              `TWR_PH_2: sda_oe_q <= 1'b1;
              default: begin
                scl_oe_q <= 1'b1;
                sh_q <= sla_byte(sel_q, stage_q == `TWR_STG_SLAR);
                bit_q <= 3'h7;
                state_q <= S_TX;
              end
            endcase
          end
        end
        S_TX: begin
          if (adv) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              `TWR_PH_0: sda_oe_q <= ~sh_q[7];
              `TWR_PH_1: scl_oe_q <= 1'b0;
              `TWR_PH_2: sda_oe_q <= sda_oe_q;
              default: begin
                scl_oe_q <= 1'b1;
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q - 3'h1;
                if (bit_q == 3'h0) begin
                  state_q <= S_RXACK;
                end
              end
            endcase
          end
        end
        S_RXACK: begin
          if (adv) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              `TWR_PH_0: sda_oe_q <= 1'b0;
              `TWR_PH_1: scl_oe_q <= 1'b0;
              `TWR_PH_2: ack_q <= ~sda_s;
              default: begin
                scl_oe_q <= 1'b1;
                bit_q <= 3'h7;
                if (!ack_q) begin
                  // Unanswered address or byte: give up cleanly
                  nack_q <= 1'b1;
                  state_q <= S_STOP;
                end else if (stage_q == `TWR_STG_SLAW) begin
                  sh_q <= addr_q[15:8];
                  stage_q <= `TWR_STG_AHI;
                  state_q <= S_TX;
                end else if (stage_q == `TWR_STG_AHI) begin
                  sh_q <= addr_q[7:0];
                  stage_q <= `TWR_STG_ALO;
                  state_q <= S_TX;
                end else if (stage_q == `TWR_STG_SLAR) begin
                  state_q <= S_RX;
                end else if ((stage_q == `TWR_STG_ALO) & rd_q) begin
                  stage_q <= `TWR_STG_SLAR;
                  state_q <= S_START;
                end else if ((stage_q == `TWR_STG_ALO) | (cnt_q == {(LEN_W + 1){1'b0}})) begin
                  stage_q <= `TWR_STG_DATA;
                  if (cnt_q == {(LEN_W + 1){1'b0}}) begin
                    state_q <= S_STOP;
                  end else begin
                    fetch_q <= 1'b1;
                    state_q <= S_FETCH;
                  end
                end else begin
                  fetch_q <= 1'b1;
                  state_q <= S_FETCH;
                end
              end
            endcase
          end
        end
        S_FETCH: begin
          // Clock parked low while the writer has no byte ready
          if (WR_VALID & fetch_q) begin
            fetch_q <= 1'b0;
            sh_q <= WR_DATA;
            bit_q <= 3'h7;
            cnt_q <= cnt_q - {{LEN_W{1'b0}}, 1'b1};
            ph_q <= `TWR_PH_0;
            state_q <= S_TX;
          end
        end
        S_RX: begin
          if (adv) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              `TWR_PH_0: sda_oe_q <= 1'b0;
              `TWR_PH_1: scl_oe_q <= 1'b0;
              `TWR_PH_2: sh_q <= {sh_q[6:0], sda_s};
              default: begin
                scl_oe_q <= 1'b1;
                bit_q <= bit_q - 3'h1;
                if (bit_q == 3'h0) begin
                  state_q <= S_PUSH;
                end
              end
            endcase
          end
        end
        S_PUSH: begin
          // Full buffer holds the clock low, so no byte is lost
          if (push) begin
            cnt_q <= cnt_q - {{LEN_W{1'b0}}, 1'b1};
            ph_q <= `TWR_PH_0;
            state_q <= S_TXACK;
          end
        end
        S_TXACK: begin
          if (adv) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              `TWR_PH_0: sda_oe_q <= (cnt_q != {(LEN_W + 1){1'b0}});
              `TWR_PH_1: scl_oe_q <= 1'b0;
              `TWR_PH_2: sda_oe_q <= sda_oe_q;
              default: begin
                scl_oe_q <= 1'b1;
                bit_q <= 3'h7;
                state_q <= (cnt_q != {(LEN_W + 1){1'b0}}) ? S_RX : S_STOP;
              end
            endcase
          end
        end
        S_STOP: begin
          if (adv) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              `TWR_PH_0: sda_oe_q <= 1'b1;
              `TWR_PH_1: scl_oe_q <= 1'b0;
              `TWR_PH_2: sda_oe_q <= 1'b0;
              default: begin
                done_q <= 1'b1;
                state_q <= S_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open-drain pins: only ever pulled low, never driven high
  assign SCL_O = 1'b0;
  assign SCL_OE = scl_oe_q;
  assign SDA_O = 1'b0;
  assign SDA_OE = sda_oe_q;
  assign BUSY = (state_q != S_IDLE);
  assign DONE = done_q;
  assign NACK = nack_q;

endmodule

// ===== tb/twr_host_assertions.sv
// Port checker for the two-wire register host controller
`timescale 1ns/10ps
module twr_host_assertions #(
  parameter PIX_MHZ = 96,
  parameter LEN_W = 8
) (
  input wire MCLK,
  input wire RST_B,
  input wire CMD_VALID,
  input wire CMD_READY,
  input wire WR_VALID,
  input wire WR_READY,
  input wire RD_VALID,
  input wire RD_READY,
  input wire [7:0] RD_DATA,
  input wire BUSY,
  input wire DONE,
  input wire NACK,
  input wire SCL_I,
  input wire SCL_O,
  input wire SCL_OE,
  input wire SDA_I,
  input wire SDA_O,
  input wire SDA_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_start;
    $rose(SDA_OE) && !SCL_OE;
  endsequence
  sequence s_stop;
    $fell(SDA_OE) && !SCL_OE;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_open_drain: assert property (!SCL_O && !SDA_O)
    else $error("line driven high");
  a_idle_free: assert property (!BUSY && !$past(BUSY) |-> !SCL_OE && !SDA_OE)
    else $error("line held while idle");
  a_take_busy: assert property (CMD_VALID && CMD_READY |=> BUSY)
    else $error("accepted command not busy");
  a_busy_refuse: assert property (BUSY |-> !CMD_READY)
    else $error("ready while busy");
  a_bus_free: assert property (CMD_READY |-> SCL_I && SDA_I && $past(SCL_I, 3) && $past(SDA_I, 3))
    else $error("ready on busy bus");
  a_start_form: assert property (s_start |-> SCL_I ##[1:4] $rose(SCL_OE))
    else $error("bad start");
  a_stop_done: assert property (s_stop |-> SCL_I ##[0:8] DONE)
    else $error("stop without done");
  a_done_pulse: assert property (DONE |=> !DONE && !BUSY)
    else $error("done not single");
  a_nack_done: assert property ($rose(NACK) |-> ##[1:40] DONE)
    else $error("nack outside done");
  a_rd_hold: assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_DATA))
    else $error("read word lost");
  a_wr_drop: assert property (WR_VALID && WR_READY |=> !WR_READY)
    else $error("write ready held");
endmodule

// ===== tb/twr_dev_model.sv
// Behavioural sensor slave on the two-wire bus
`timescale 1ns/10ps
module twr_dev_model (
  input wire scl,
  input wire sda,
  input wire sel,
  input wire slow,
  output logic sda_pull,
  output logic scl_pull
);
  logic [7:0] mem [0:65535];
  logic [7:0] sh = 8'h00;
  logic [7:0] cur = 8'h00;
  logic [15:0] ptr = 16'h0000;
  logic act = 1'b0;
  logic snd = 1'b0;
  int bitn = 0;
  int stg = 0;
  initial sda_pull = 1'b0;
  initial scl_pull = 1'b0;
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    snd = 1'b0;
    bitn = 0;
    stg = 0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    snd = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
      bitn = bitn + 1;
    end else begin
      bitn = 0;
      if (snd && sda) act = 1'b0;
    end
  end
  always @(negedge scl) if (act) begin
    if (bitn == 8 && snd) begin
      sda_pull = 1'b0;
    end else if (bitn == 8) begin
      if (stg == 0 && {sh[7:1], 1'b0} != (sel ? 8'hBA : 8'h90)) begin
        act = 1'b0;
      end else begin
        sda_pull = 1'b1;
        case (stg)
          0: snd = sh[0];
          1: ptr[15:8] = sh;
          2: ptr[7:0] = sh;
          default: begin
            mem[ptr] = sh;
            ptr = ptr + 16'h0001;
          end
        endcase
        if (stg < 3) stg = stg + 1;
      end
    end else begin
      if (snd && bitn == 0) begin
        cur = mem[ptr];
        ptr = ptr + 16'h0001;
      end
      sda_pull = snd & ~cur[7 - bitn];
    end
  end
  // Stretch lets the host prove it waits on a slow slave
  always @(negedge scl) if (act && slow) begin
    scl_pull = 1'b1;
    #37 scl_pull = 1'b0;
  end
endmodule

// ===== tb/twr_host_tb.sv
// Self-checking bench for the two-wire register host controller
`timescale 1ns/10ps
module twr_host_tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_cur = 1'b0, cmd_sel = 1'b0;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_words = 8'h00, wr_data = 8'h00;
  logic wr_valid = 1'b0, rd_ready = 1'b0, dev_sel = 1'b0, slow = 1'b0, nack_got;
  wire cmd_ready, wr_ready, rd_valid, busy, done, nack, scl_o, scl_oe, sda_o, sda_oe;
  wire dev_sda, dev_scl;
  wire [7:0] rd_data;
  wire scl_w = !(scl_oe || dev_scl);
  wire sda_w = !(sda_oe || dev_sda);
  logic [7:0] exp_mem [0:65535];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  integer seed = 40501;
  int odds = 32;
  int bad_count = 0, check_count = 0;
  always #2.5 mclk = ~mclk;
  twr_host #(.PIX_MHZ(1100), .LEN_W(8)) i_twr_host (
    .MCLK(mclk), .RST_B(rst_b), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_READ(cmd_read), .CMD_CUR(cmd_cur), .CMD_SEL(cmd_sel), .CMD_ADDR(cmd_addr),
    .CMD_WORDS(cmd_words), .WR_VALID(wr_valid), .WR_READY(wr_ready), .WR_DATA(wr_data),
    .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data), .BUSY(busy),
    .DONE(done), .NACK(nack), .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe),
    .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe));
  twr_dev_model i_twr_dev_model (.scl(scl_w), .sda(sda_w), .sel(dev_sel), .slow(slow),
    .sda_pull(dev_sda), .scl_pull(dev_scl));
  ////////////////////////////////////////////////////////////////////////////
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One command end to end; write bytes come from wq, read bytes land in rq
  task run(input logic rd, input logic cur, input logic sel, input int a, input int w);
    int n;
    logic tw, tr, fin;
    logic [7:0] d;
    n = 0;
    fin = 1'b0;
    rq.delete();
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_cur <= cur;
    cmd_sel <= sel;
    cmd_addr <= a[15:0];
    cmd_words <= w[7:0];
    wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
    do begin
      @(negedge mclk);
      n++;
    end while (!cmd_ready && n < 4000);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    while (!(fin && !rd_valid) && n < 40000) begin
      @(negedge mclk);
      n++;
      tw = wr_valid && wr_ready;
      tr = rd_valid && rd_ready;
      d = rd_data;
      if (done) begin
        fin = 1'b1;
        nack_got = nack;
      end
      @(posedge mclk);
      if (tw) wq.delete(0);
      if (tr) rq.push_back(d);
      wr_data <= (wq.size() > 0) ? wq[0] : 8'h00;
      wr_valid <= 1'($random(seed));
      rd_ready <= (($random(seed) & 63) < odds);
    end
    wq.delete();
    if (n >= 40000) begin
      bad_count++;
      summarize();
    end
  endtask
  initial begin
    int a, w, i, k;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    for (i = 0; i < 6; i++) begin
      dev_sel <= i[0];
      slow <= i[1];
      odds = (i == 4) ? 1 : 32;
      a = $random(seed) & 32'h0000FFF0;
      w = 2 + ($random(seed) & 3);
      for (k = 0; k < 2 * w; k++) begin
        wq.push_back(8'($random(seed)));
        exp_mem[a + k] = wq[k];
      end
      run(1'b0, 1'b0, i[0], a, w);
      chk1(nack_got, 1'b0);
      run(1'b0, 1'b0, i[0], a, 0);
      run(1'b1, 1'b1, i[0], a, 1);
      chk8(8'(rq.size()), 8'h02);
      for (k = 0; k < 2; k++) chk8(rq[k], exp_mem[a + k]);
      run(1'b1, 1'b0, i[0], a + 2, w - 1);
      chk8(8'(rq.size()), 8'(2 * w - 2));
      for (k = 0; k < 2 * w - 2; k++) chk8(rq[k], exp_mem[a + 2 + k]);
      $display("test %0d done", i);
    end
    dev_sel <= 1'b0;
    odds = 32;
    wq.push_back(~exp_mem[a]);
    wq.push_back(~exp_mem[a + 1]);
    run(1'b0, 1'b0, 1'b1, a, 1);
    chk1(nack_got, 1'b1);
    run(1'b1, 1'b1, 1'b1, a, 0);
    chk1(nack_got, 1'b1);
    run(1'b1, 1'b0, 1'b0, a, 1);
    chk1(nack_got, 1'b0);
    for (k = 0; k < 2; k++) chk8(rq[k], exp_mem[a + k]);
    $display("test refused done");
    summarize();
  end
endmodule
bind twr_host twr_host_assertions #(.PIX_MHZ(PIX_MHZ), .LEN_W(LEN_W)) i_twr_host_assertions (
  .MCLK(MCLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
  .WR_VALID(WR_VALID), .WR_READY(WR_READY), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
  .RD_DATA(RD_DATA), .BUSY(BUSY), .DONE(DONE), .NACK(NACK), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE));
